// ### usr_pkg.sv
package usr_pkg;

    // Clock rate of aclk
    localparam int CLK_MHZ = 10;

    // Register byte offsets on the AXI4-Lite port
    localparam logic [3:0] REG_CTRL_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_EVENT_OFS = 4'h8;

    // Control register fields
    localparam int CTRL_CONNECT_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int CTRL_SUSPEND_BIT = 2;
    localparam logic CTRL_CONNECT_RST = 1'b0;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_HS_BIT = 11;
    localparam int STAT_LINE_LSB = 12;
    localparam int STAT_CLK_BIT = 14;
    localparam int STAT_VBUS_BIT = 15;

    // Event register fields, write one to clear
    localparam int EVT_BUS_RESET_BIT = 0;
    localparam int EVT_HOST_RESUME_BIT = 1;
    localparam int EVT_WAKE_DONE_BIT = 2;
    localparam int EVT_HS_DONE_BIT = 3;
    localparam int EVT_FS_FALLBACK_BIT = 4;
    localparam int EVT_W = 5;
    localparam logic [EVT_W-1:0] EVT_RST = 5'h00;

    // Interval lengths in their own units
    localparam int T_DEBOUNCE_US = 100000;
    localparam int T_CHIRP_US = 1100;
    localparam int T_LISTEN_US = 2500;
    localparam int T_IDLE_US = 5000;
    localparam int T_WAKE_START_US = 9000;
    localparam int T_WAKE_K_US = 2000;
    localparam int T_FILT_NS = 2500;

    // Interval lengths in aclk cycles; least times round up
    localparam int DEBOUNCE_CYC = T_DEBOUNCE_US * CLK_MHZ;
    localparam int CHIRP_CYC = T_CHIRP_US * CLK_MHZ;
    localparam int LISTEN_CYC = T_LISTEN_US * CLK_MHZ;
    localparam int IDLE_CYC = T_IDLE_US * CLK_MHZ;
    localparam int WAKE_START_CYC = T_WAKE_START_US * CLK_MHZ;
    localparam int WAKE_K_CYC = T_WAKE_K_US * CLK_MHZ;
    localparam int FILT_CYC = (T_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int CHIRP_PAIRS = 6;

    // Transceiver and bus response encodings
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_NODRIVE = 2'h1;
    localparam logic [1:0] OPM_RAW = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states, one-hot
    typedef enum logic [10:0] {
        ST_DETACH = 11'h001,
        ST_ATTACH = 11'h002,
        ST_RUN = 11'h004,
        ST_SUSP = 11'h008,
        ST_CLKWAIT = 11'h010,
        ST_CHIRP = 11'h020,
        ST_LISTEN = 11'h040,
        ST_WAKEWAIT = 11'h080,
        ST_WAKEK = 11'h100,
        ST_WAKEEND = 11'h200,
        ST_HRES = 11'h400
    } usr_state_t;

endpackage

// ### usr_line_filter.sv
`timescale 1ns/1ps
`default_nettype none

module usr_line_filter
    import usr_pkg::*;
#(
    parameter int STABLE_CYC = FILT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] line_in,
    output logic [1:0] line_out
);

    if (STABLE_CYC < 1 || STABLE_CYC > 255) begin : g_chk
        $error("usr_line_filter: STABLE_CYC out of range");
    end

    logic [1:0] last_reg;
    logic [7:0] cnt_reg;
    logic [1:0] out_reg;
    wire changed = (line_in != last_reg);
    wire settled = (cnt_reg >= 8'(STABLE_CYC - 1));

    // A line value is passed on only after it held still long enough
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_reg <= LS_J;
            cnt_reg <= 8'h00;
            out_reg <= LS_J;
        end else begin
            last_reg <= line_in;
            cnt_reg <= changed ? 8'h00 : (settled ? cnt_reg : cnt_reg + 8'h01);
            if (!changed && settled) begin
                out_reg <= line_in;
            end
        end
    end

    assign line_out = out_reg;

endmodule

`default_nettype wire

// ### usr_seq.sv
// Functional notes
// R1 - On SE0 during suspend, raise suspend pin and start handshake; pull-up on, HS terms off.
// R2 - Transceiver gives first clock within 5.6 ms, only once usable.
// R3 - Chirp K starts after first clock, before 5.8 ms from reference.
// R4 - Chirp K lasts at least 1 ms, ends before 7 ms, then listen for host.
// R5 - Transceiver clock reaches nominal accuracy by 20 ms after reference.
// R6 - Remote wake waits for at least 5 ms idle bus.
// R7 - Resume K begins within 10 ms of wake; suspend pin may rise at start.
// R8 - Resume K uses raw opmode, full-speed selects, txvalid, zero data, 1 ms minimum.
// R9 - Resume K released between 1 ms and 15 ms after start.
// R10 - Restore high-speed within 1.33 us after host SE0 ends resume.
// R11 - Full-speed device keeps term and xcvr selects high after resume.
// R12 - Host resume tracked as J-to-K then full-speed EOP on line state.
// R13 - Host resume K lasts 20 ms; suspend pin may rise at its start.
// R14 - Leave suspend on J-to-K transition, not on the SE0.
// R15 - Within 1.25 us of EOP SE0 return to pre-suspend speed.
// R16 - Full-speed resume keeps full-speed terminations on.
// R17 - High-speed resume switches terminations before SE0 expires.
// R18 - On attach set full-speed selects and pull-up, within 100 ms of VBUS.
// R19 - After 100 ms debounce, SE0 on line means bus reset, then handshake.
// R20 - Chirp K timed long enough for 1 ms even at clock tolerance.
// R21 - Host chirp K or J accepted only after 2.5 us stable line.
// R22 - All intervals come from counters sized for worst-case clock.
`timescale 1ns/1ps
`default_nettype none

module usr_seq
    import usr_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int TIMER_W = 24,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int CHIRP_CYCLES = CHIRP_CYC,
    parameter int LISTEN_CYCLES = LISTEN_CYC,
    parameter int IDLE_CYCLES = IDLE_CYC,
    parameter int WAKE_START_CYCLES = WAKE_START_CYC,
    parameter int WAKE_K_CYCLES = WAKE_K_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transceiver side
    input wire logic vbus_valid,
    input wire logic xcvr_clkout,
    input wire logic [1:0] linestate,
    output logic suspendn,
    output logic [1:0] opmode,
    output logic xcvrselect,
    output logic termselect,
    output logic txvalid,
    output logic [7:0] tx_data
);

    if (ADDR_W < 4 || TIMER_W > 31 || DEBOUNCE_CYCLES >= (1 << TIMER_W)
        || CHIRP_CYCLES < 1 || LISTEN_CYCLES < 1 || IDLE_CYCLES < 1
        || WAKE_START_CYCLES < 1 || WAKE_K_CYCLES < 1
        || CHIRP_CYCLES >= (1 << TIMER_W) || LISTEN_CYCLES >= (1 << TIMER_W)
        || IDLE_CYCLES >= (1 << TIMER_W) || WAKE_START_CYCLES >= (1 << TIMER_W)
        || WAKE_K_CYCLES >= (1 << TIMER_W)) begin : g_chk
        $error("usr_seq: parameter out of range");
    end

    // Pin synchronisers; logic reads the second stage, and also the third stage of the clock pin
    logic [1:0] ls_s1_reg, ls_s2_reg;
    logic vb_s1_reg, vb_s2_reg, ck_s1_reg, ck_s2_reg, ck_s3_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ls_s1_reg <= LS_J;
            ls_s2_reg <= LS_J;
            vb_s1_reg <= 1'b0;
            vb_s2_reg <= 1'b0;
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
        end else begin
            ls_s1_reg <= linestate;
            ls_s2_reg <= ls_s1_reg;
            vb_s1_reg <= vbus_valid;
            vb_s2_reg <= vb_s1_reg;
            ck_s1_reg <= xcvr_clkout;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
        end
    end

    // Filtered line for chirp and reset decisions
    logic [1:0] ls_filt;
    usr_line_filter #(
        .STABLE_CYC(FILT_CYC)
    ) u_filt (
        .aclk(aclk),
        .aresetn(aresetn),
        .line_in(ls_s2_reg),
        .line_out(ls_filt)
    );

    // Register state and sequencer state
    usr_state_t state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic connect_reg, hs_mode_reg, hs_mode_next, clk_seen_reg, wake_pend_reg;
    logic [EVT_W-1:0] evt_reg, evt_set;
    logic [1:0] filt_prev_reg, ls_prev_reg;
    logic [2:0] chirp_cnt_reg;
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // Unit that turns a cycle count into a reached flag
    function automatic logic reached(input logic [TIMER_W-1:0] t, input int n);
        reached = (t >= TIMER_W'(n - 1));
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[3:0] == REG_CTRL_OFS) || (a[3:0] == REG_STATUS_OFS)
            || (a[3:0] == REG_EVENT_OFS);
    endfunction

    // Write channel decode; address and data may arrive in either order
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [ADDR_W-1:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire do_write = (aw_hold_reg || aw_take) && (w_hold_reg || w_take) && !bvalid_reg;
    wire wr_lane0 = do_write && wr_strb[0];
    wire wr_ctrl = wr_lane0 && (wr_addr[3:0] == REG_CTRL_OFS);
    wire wr_evt = wr_lane0 && (wr_addr[3:0] == REG_EVENT_OFS);
    wire wake_cmd = wr_ctrl && wr_data[CTRL_WAKE_BIT];
    wire suspend_cmd = wr_ctrl && wr_data[CTRL_SUSPEND_BIT];
    wire [EVT_W-1:0] evt_clr = wr_evt ? wr_data[EVT_W-1:0] : '0;

    // Read channel decode
    assign s_axi_arready = !rvalid_reg;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {16'h0000, vb_s2_reg, clk_seen_reg, ls_s2_reg,
        hs_mode_reg, state_reg};
    wire [31:0] rd_word = (s_axi_araddr[3:0] == REG_CTRL_OFS) ? {31'h0, connect_reg}
        : (s_axi_araddr[3:0] == REG_STATUS_OFS) ? status_word
        : (s_axi_araddr[3:0] == REG_EVENT_OFS) ? {27'h0, evt_reg} : 32'h0;

    // Bus slave registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bresp_reg <= RESP_OKAY;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else begin
            aw_hold_reg <= (aw_hold_reg || aw_take) && !do_write;
            w_hold_reg <= (w_hold_reg || w_take) && !do_write;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Line conditions seen by the sequencer
    wire online = connect_reg && vb_s2_reg;
    wire ck_edge = (ck_s2_reg != ck_s3_reg);
    wire raw_se0 = (ls_s2_reg == LS_SE0);
    wire j_to_k = (ls_prev_reg == LS_J) && (ls_s2_reg == LS_K);
    wire filt_new = (ls_filt != filt_prev_reg);
    wire [1:0] chirp_want = chirp_cnt_reg[0] ? LS_J : LS_K;
    wire chirp_hit = filt_new && (ls_filt == chirp_want);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        hs_mode_next = hs_mode_reg;
        evt_set = '0;
        case (state_reg)
            ST_DETACH: begin
                hs_mode_next = 1'b0;
                if (online) begin
                    state_next = ST_ATTACH; // R18
                end
            end
            ST_ATTACH: begin
                if (reached(timer_reg, DEBOUNCE_CYCLES)) begin // R19
                    if (ls_filt == LS_SE0) begin
                        state_next = ST_CHIRP;
                        evt_set[EVT_BUS_RESET_BIT] = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!hs_mode_reg && ls_filt == LS_SE0) begin
                    state_next = ST_CHIRP;
                    evt_set[EVT_BUS_RESET_BIT] = 1'b1;
                end else if (suspend_cmd) begin
                    state_next = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (raw_se0) begin
                    state_next = ST_CLKWAIT; // R1
                    hs_mode_next = 1'b0;
                    evt_set[EVT_BUS_RESET_BIT] = 1'b1;
                end else if (j_to_k) begin
                    state_next = ST_HRES; // R14
                end else if (wake_pend_reg && reached(timer_reg, IDLE_CYCLES)) begin
                    state_next = ST_WAKEWAIT; // R6
                end
            end
            ST_CLKWAIT: begin
                if (clk_seen_reg) begin
                    state_next = ST_CHIRP; // R3
                end
            end
            ST_CHIRP: begin
                hs_mode_next = 1'b0;
                if (reached(timer_reg, CHIRP_CYCLES)) begin // R4 R20
                    state_next = ST_LISTEN;
                end
            end
            ST_LISTEN: begin
                if (chirp_hit && chirp_cnt_reg == 3'(CHIRP_PAIRS - 1)) begin // R21
                    state_next = ST_RUN;
                    hs_mode_next = 1'b1;
                    evt_set[EVT_HS_DONE_BIT] = 1'b1;
                end else if (reached(timer_reg, LISTEN_CYCLES)) begin
                    state_next = ST_RUN;
                    evt_set[EVT_FS_FALLBACK_BIT] = 1'b1;
                end
            end
            ST_WAKEWAIT: begin
                if (clk_seen_reg || reached(timer_reg, WAKE_START_CYCLES)) begin // R7
                    state_next = ST_WAKEK;
                end
            end
            ST_WAKEK: begin
                if (reached(timer_reg, WAKE_K_CYCLES)) begin // R9
                    state_next = ST_WAKEEND;
                end
            end
            ST_WAKEEND, ST_HRES: begin
                if (raw_se0) begin
                    state_next = ST_RUN; // R10 R15 R12
                    evt_set[EVT_HOST_RESUME_BIT] = (state_reg == ST_HRES);
                    evt_set[EVT_WAKE_DONE_BIT] = (state_reg == ST_WAKEEND);
                end
            end
            default: begin
                state_next = ST_DETACH;
            end
        endcase
        if (!online) begin
            state_next = ST_DETACH;
        end
    end

    // Transceiver controls for the coming state
    wire nx_susp = (state_next == ST_SUSP);
    wire nx_raw = (state_next == ST_CHIRP) || (state_next == ST_WAKEK);
    wire nx_hs_sel = (state_next == ST_CHIRP) || (state_next == ST_LISTEN)
        || ((state_next == ST_RUN || nx_susp) && hs_mode_next);
    wire nx_hs_term = (state_next == ST_RUN || nx_susp) && hs_mode_next;
    wire [1:0] nx_opmode = (state_next == ST_DETACH) ? OPM_NODRIVE
        : nx_raw ? OPM_RAW : OPM_NORMAL; // R8

    // Sequencer registers; outputs come from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_DETACH;
            timer_reg <= '0;
            hs_mode_reg <= 1'b0;
            clk_seen_reg <= 1'b0;
            wake_pend_reg <= 1'b0;
            connect_reg <= CTRL_CONNECT_RST;
            evt_reg <= EVT_RST;
            filt_prev_reg <= LS_J;
            ls_prev_reg <= LS_J;
            chirp_cnt_reg <= 3'h0;
            suspendn <= 1'b1;
            opmode <= OPM_NODRIVE;
            xcvrselect <= 1'b1;
            termselect <= 1'b1;
            txvalid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            state_reg <= state_next;
            // Saturates, so a long stay never wraps into a false expiry
            if (state_next != state_reg) begin
                timer_reg <= '0; // R22
            end else if (timer_reg != '1) begin
                timer_reg <= timer_reg + TIMER_W'(1);
            end
            hs_mode_reg <= hs_mode_next;
            // Clock presence is only judged after the suspend pin rises
            clk_seen_reg <= nx_susp ? 1'b0 : (clk_seen_reg || ck_edge); // R2
            if (wake_cmd) begin
                wake_pend_reg <= 1'b1;
            end else if (state_reg == ST_WAKEWAIT || state_reg == ST_DETACH) begin
                wake_pend_reg <= 1'b0;
            end
            if (wr_ctrl) begin
                connect_reg <= wr_data[CTRL_CONNECT_BIT];
            end
            // Hardware set wins over a software clear in the same cycle
            evt_reg <= (evt_reg & ~evt_clr) | evt_set;
            filt_prev_reg <= ls_filt;
            ls_prev_reg <= ls_s2_reg;
            if (state_reg != ST_LISTEN) begin
                chirp_cnt_reg <= 3'h0;
            end else if (chirp_hit) begin
                chirp_cnt_reg <= chirp_cnt_reg + 3'h1;
            end
            suspendn <= !nx_susp; // R7 R13
            opmode <= nx_opmode;
            xcvrselect <= !nx_hs_sel; // R11 R16
            termselect <= !nx_hs_term; // R17
            txvalid <= nx_raw; // R8
            tx_data <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// ### usr_seq_props.sv
`timescale 1ns/1ps
`default_nettype none

module usr_seq_props
    import usr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic vbus_valid,
    input wire logic suspendn,
    input wire logic [1:0] opmode,
    input wire logic xcvrselect,
    input wire logic termselect,
    input wire logic txvalid,
    input wire logic [7:0] tx_data
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Any K driven by us must bypass stuffing and carry zeros
    a_tx_raw_mode: assert property (txvalid |-> opmode == OPM_RAW)
        else $error("txvalid outside raw mode");
    a_tx_zero_data: assert property (txvalid |-> tx_data == 8'h00)
        else $error("nonzero data during K");
    a_chirp_pullup: assert property (txvalid && !xcvrselect |-> termselect)
        else $error("chirp without pull-up");
    a_resume_fs_terms: assert property (txvalid && xcvrselect |-> termselect)
        else $error("resume K not in full speed");
    a_k_min_width: assert property ($rose(txvalid) |=> txvalid [*8])
        else $error("K released too soon");
    a_k_only_awake: assert property (txvalid |-> suspendn)
        else $error("K driven while suspended");
    a_hs_terms_pair: assert property (!termselect |-> !xcvrselect)
        else $error("hs terminations without hs transceiver");
    a_detach_quick: assert property ($fell(vbus_valid) |-> ##[1:6] opmode == OPM_NODRIVE)
        else $error("no detach after vbus loss");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
endmodule

bind usr_seq usr_seq_props chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .vbus_valid(vbus_valid),
    .suspendn(suspendn), .opmode(opmode), .xcvrselect(xcvrselect),
    .termselect(termselect), .txvalid(txvalid), .tx_data(tx_data)
);

`default_nettype wire

// ### usr_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none

module usr_xcvr_model #(
    parameter int START_NS = 3000,
    parameter int HALF_NS = 65
) (
    input wire logic suspendn,
    output logic clkout
);
    // Oscillator: silent while suspended, no edge until it is usable
    initial begin
        clkout = 1'b0;
        forever begin
            wait (suspendn === 1'b1);
            #(START_NS);
            while (suspendn === 1'b1) begin
                #(HALF_NS) clkout = ~clkout;
            end
        end
    end
endmodule

`default_nettype wire

// ### usr_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none

module usr_seq_bench
    import usr_pkg::*;
;
    localparam int WK = 100;
    logic aclk = 1'b0, aresetn = 1'b0, vbus_valid = 1'b0, clkout;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [2:0] prot = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, suspendn, xcvrselect, termselect, txvalid;
    logic [1:0] bresp, rresp, opmode, linestate = LS_SE0;
    logic [7:0] tx_data;
    int fails = 0, compares = 0;

    usr_seq #(.DEBOUNCE_CYCLES(200), .CHIRP_CYCLES(100), .LISTEN_CYCLES(2000),
        .IDLE_CYCLES(50), .WAKE_START_CYCLES(100), .WAKE_K_CYCLES(WK)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(prot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vbus_valid(vbus_valid),
        .xcvr_clkout(clkout), .linestate(linestate), .suspendn(suspendn),
        .opmode(opmode), .xcvrselect(xcvrselect), .termselect(termselect),
        .txvalid(txvalid), .tx_data(tx_data));
    usr_xcvr_model xcvr (.suspendn(suspendn), .clkout(clkout));

    // 10 MHz clock
    initial begin
        forever #50 aclk = ~aclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Readies are combinational on state, so they are sampled mid-cycle
    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && (awready === 1'b1);
            tw = wvalid && (wready === 1'b1);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!(ta || !awvalid) || !(tw || !wvalid));
        do begin
            @(negedge aclk);
        end while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(er));
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge aclk);
        end while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
        end while (rvalid !== 1'b1);
        d = rdata; r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task wait_state(input usr_state_t s);
        int n;
        logic [31:0] d;
        logic [1:0] r;
        n = 0;
        do begin
            axi_rd(REG_STATUS_OFS, d, r);
            n++;
        end while (d[10:0] !== s && n < 1000);
        chk(32'(d[10:0]), 32'(s));
    endtask

    // Check one event flag is set, then clear it
    task evt(input int b);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(REG_EVENT_OFS, d, r);
        chk(32'(d[b]), 32'h1);
        axi_wr(REG_EVENT_OFS, 32'h1 << b, RESP_OKAY);
    endtask

    task hs_back(input int b);
        @(posedge aclk) linestate <= LS_SE0;
        repeat (12) @(posedge aclk);
        #1 chk(32'({xcvrselect, termselect}), 32'h0);
        @(posedge aclk) linestate <= LS_J;
        evt(b);
    endtask

    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        chk(32'({suspendn, opmode, termselect, txvalid}), 32'h16);
        axi_rd(4'hC, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        axi_wr(4'hC, 32'h1, RESP_SLVERR);
        // Low lane disabled: the connect bit must not move
        wstrb <= 4'h0;
        prot <= 3'h2;
        axi_wr(REG_CTRL_OFS, 32'h1, RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(REG_CTRL_OFS, d, r);
        chk(d & 32'h7, 32'h0);
    endtask

    task t_attach_hs;
        int i;
        vbus_valid <= 1'b1;
        axi_wr(REG_CTRL_OFS, 32'h1, RESP_OKAY);
        wait_state(ST_ATTACH);
        chk(32'({xcvrselect, termselect, opmode}), 32'hC);
        wait_state(ST_CHIRP);
        wait_state(ST_LISTEN);
        for (i = 0; i < 6; i++) begin
            @(posedge aclk) linestate <= i[0] ? LS_J : LS_K;
            repeat (39) @(posedge aclk);
        end
        wait_state(ST_RUN);
        linestate <= LS_J;
        chk(32'({xcvrselect, termselect}), 32'h0);
        evt(EVT_HS_DONE_BIT);
    endtask

    task t_host_resume;
        axi_wr(REG_CTRL_OFS, 32'h5, RESP_OKAY);
        wait_state(ST_SUSP);
        chk(32'(suspendn), 32'h0);
        @(posedge aclk) linestate <= LS_K;
        repeat (6) @(posedge aclk);
        #1 chk(32'({suspendn, xcvrselect, termselect}), 32'h7);
        repeat (20) @(posedge aclk);
        hs_back(EVT_HOST_RESUME_BIT);
    endtask

    task t_wake;
        int n;
        axi_wr(REG_CTRL_OFS, 32'h5, RESP_OKAY);
        wait_state(ST_SUSP);
        repeat (60) @(posedge aclk);
        axi_wr(REG_CTRL_OFS, 32'h3, RESP_OKAY);
        n = 0;
        while (txvalid !== 1'b1 && n < 2000) begin
            @(negedge aclk);
            n++;
        end
        chk(32'({suspendn, opmode, xcvrselect, termselect}), 32'h1B);
        n = 0;
        while (txvalid === 1'b1 && n < 3000) begin
            @(negedge aclk);
            n++;
        end
        chk(32'(n >= WK && n < WK + 4), 32'h1);
        @(posedge aclk) linestate <= LS_K;
        repeat (20) @(posedge aclk);
        hs_back(EVT_WAKE_DONE_BIT);
    endtask

    task t_susp_reset;
        axi_wr(REG_CTRL_OFS, 32'h5, RESP_OKAY);
        wait_state(ST_SUSP);
        @(posedge aclk) linestate <= LS_SE0;
        repeat (8) @(posedge aclk);
        #1 chk(32'(suspendn), 32'h1);
        wait_state(ST_CHIRP);
        chk(32'({txvalid, xcvrselect, termselect}), 32'h5);
        linestate <= LS_J;
        wait_state(ST_RUN);
        chk(32'(xcvrselect), 32'h1);
        evt(EVT_FS_FALLBACK_BIT);
        vbus_valid <= 1'b0;
        wait_state(ST_DETACH);
        chk(32'(opmode), 32'(OPM_NODRIVE));
    endtask

    task close_out;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence; reset held five cycles
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_regs;
        t_attach_hs;
        t_host_resume;
        t_wake;
        t_susp_reset;
        close_out;
    end

    // Whole run needs well under 30000 cycles
    initial begin
        repeat (60000) @(posedge aclk);
        fails++;
        close_out;
    end
endmodule

`default_nettype wire
